// ### rtl/bra_map.vh
// register map, field positions, reset values and stop values for the bus release arbiter
`ifndef BRA_MAP_VH
`define BRA_MAP_VH

// register byte offsets
`define BRA_OFS_CTRL      4'h0
`define BRA_OFS_MSTP      4'h4
`define BRA_OFS_STAT      4'h8

// control register fields
`define BRA_CTRL_RLS_EN   0
`define BRA_CTRL_DROP_EN  1

// status register fields
`define BRA_ST_RELEASED   0
`define BRA_ST_DRAIN      1
`define BRA_ST_CPU_ACK    2
`define BRA_ST_DTC_ACK    3
`define BRA_ST_STOPPED    4
`define BRA_ST_REQ_SEEN   5
`define BRA_ST_DROP_REQ   6
`define BRA_ST_MAN_RST    7

// reset values
`define BRA_CTRL_RST      2'h0
`define BRA_MSTP_RST      16'h3fff

// module stop values that halt the release function in sleep
`define BRA_MSTP_STOP_A   16'hffff
`define BRA_MSTP_STOP_B   16'hefff

// synchroniser reset level of the sampled pins
`define BRA_SYNC_RST      3'h3

`endif

// ### rtl/bra_sync.v
// two flip-flop synchroniser for pins that arrive from outside the clock domain
module bra_sync #(
	parameter       WIDTH   = 3,
	parameter       RST_VAL = 3'h3
) (
	// clock and reset
	input  wire             CLK_SYS,
	input  wire             NRST,
	// asynchronous levels in, synchronised levels out
	input  wire [WIDTH-1:0] ASYNC_IN,
	output wire [WIDTH-1:0] SYNC_OUT
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// first stage feeds only the second stage
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= ASYNC_IN;
			sync_q <= meta_q;
		end
	end

	assign SYNC_OUT = sync_q;

endmodule

// ### rtl/bra_bus_release_arbiter.v
// bus release arbiter: internal master arbitration and external bus hand-over
//
// Summary of operation
// (R1) grant the external bus only in expansion mode with release enabled
// (R2) low request input leads to low grant and floated bus pins
// (R3) during release internal access continues; external cycles wait for request removal
// (R4) with drop enable set, a pending external access drives drop request low
// (R5) request input high ends release and raises the grant output
// (R6) simultaneous release request and external access: release wins
// (R7) released state floats address, data, selects, strobes and write strobes
// (R8) sleep with an all-stop module stop value halts the release function
// (R9) acknowledge the requester or highest-priority one; it keeps bus until withdrawn
// (R10) transfer controller has priority over the cpu
// (R11) internal bus access runs alongside an external release
// (R12) cpu yields only at cycle breaks, never inside a split access
// (R13) a sleeping cpu yields at once to the transfer controller
// (R14) transfer controller raises its request on every activation
// (R15) transfer controller yields only between its unit operations
// (R16) release starts only after the current external cycle ends
// (R17) power-on reset resets at once and abandons any cycle
// (R18) manual reset keeps state, finishes the cycle, ignores wait
// (R19) the request input is synchronised before use
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`include "bra_map.vh"

module bra_bus_release_arbiter #(
	parameter AREAS = 8
) (
	// clock and power-on reset
	input  wire             CLK_SYS,
	input  wire             NRST,
	// wishbone slave
	input  wire             WB_CYC_I,
	input  wire             WB_STB_I,
	input  wire             WB_WE_I,
	input  wire [3:0]       WB_ADR_I,
	input  wire [3:0]       WB_SEL_I,
	input  wire [31:0]      WB_DAT_I,
	output wire [31:0]      WB_DAT_O,
	output wire             WB_ACK_O,
	// mode and reset pins
	input  wire             EXT_MODE,
	input  wire             MAN_RST_N,
	input  wire             SLEEP,
	// release handshake pins
	input  wire             EXT_BUS_REQUEST_N,
	output wire             BUS_GRANT_N,
	output wire             DROP_REQUEST_OUT_N,
	// cpu master
	input  wire             CPU_REQ,
	input  wire             CPU_BREAK,
	input  wire             CPU_EXT_REQ,
	output wire             CPU_ACK,
	// transfer controller master
	input  wire             TC_ACTIVATE,
	input  wire             TC_DONE,
	input  wire             TC_BREAK,
	input  wire             TC_EXT_REQ,
	output wire             TC_ACK,
	// bus cycle engine
	input  wire             EXT_BUSY,
	output wire             EXT_GO,
	output wire             WAIT_IGNORE,
	// pin values from the bus cycle engine
	input  wire [23:0]      ADDR_I,
	input  wire [15:0]      DATA_I,
	input  wire             DATA_DRIVE,
	input  wire [AREAS-1:0] AREA_SELECT_N_I,
	input  wire             ADDRESS_STROBE_N_I,
	input  wire             READ_STROBE_N_I,
	input  wire             UPPER_WRITE_STROBE_N_I,
	input  wire             LOWER_WRITE_STROBE_N_I,
	// bus pins, output enables low while driving
	output wire [23:0]      ADDR_O,
	output wire             ADDR_OE_N,
	output wire [15:0]      DATA_O,
	output wire             DATA_OE_N,
	output wire [AREAS-1:0] AREA_SELECT_N_O,
	output wire             AREA_SELECT_OE_N,
	output wire             ADDRESS_STROBE_N_O,
	output wire             READ_STROBE_N_O,
	output wire             UPPER_WRITE_STROBE_N_O,
	output wire             LOWER_WRITE_STROBE_N_O,
	output wire             STROBE_OE_N
);

	// release state machine, one-hot
	localparam [2:0] RS_OWN   = 3'h1;
	localparam [2:0] RS_DRAIN = 3'h2;
	localparam [2:0] RS_REL   = 3'h4;

	// internal bus holder, one-hot
	localparam [2:0] HD_NONE  = 3'h1;
	localparam [2:0] HD_CPU   = 3'h2;
	localparam [2:0] HD_TC    = 3'h4;

	// true when the module stop value halts release in sleep
	function all_stop;
		input [15:0] v;
		begin
			all_stop = (v == `BRA_MSTP_STOP_A) || (v == `BRA_MSTP_STOP_B);
		end
	endfunction

	// byte-lane merge for register writes
	function [15:0] lane_merge;
		input [15:0] old;
		input [15:0] wr;
		input [1:0]  sel;
		begin
			lane_merge[7:0]  = sel[0] ? wr[7:0]  : old[7:0];
			lane_merge[15:8] = sel[1] ? wr[15:8] : old[15:8];
		end
	endfunction

	wire [2:0] pins_sync;
	wire       req_low;
	wire       man_rst;
	wire       mode_ext;

	reg [1:0]  ctrl_q;
	reg [15:0] mstp_q;
	reg        ack_q;
	reg [31:0] rdat_q;
	reg [2:0]  rs_q;
	reg [2:0]  rs_d;
	reg [2:0]  hd_q;
	reg [2:0]  hd_d;
	reg        tc_req_q;
	reg        grant_n_q;
	reg        drop_n_q;

	reg [23:0]      addr_q;
	reg [15:0]      data_q;
	reg             data_oe_n_q;
	reg             pins_oe_n_q;
	reg [AREAS-1:0] cs_n_q;
	reg             as_n_q;
	reg             rd_n_q;
	reg             hwr_n_q;
	reg             lwr_n_q;

	wire       stopped;
	wire       rls_ok;
	wire       rls_want;
	wire       int_ext_req;
	wire       wb_req;
	wire [31:0] stat_word;

	// request, manual reset and mode pins pass two flops first
	bra_sync #(
		.WIDTH   (3),
		.RST_VAL (`BRA_SYNC_RST)
	) u_sync (
		.CLK_SYS  (CLK_SYS),
		.NRST     (NRST),
		.ASYNC_IN ({EXT_MODE, MAN_RST_N, EXT_BUS_REQUEST_N}),
		.SYNC_OUT (pins_sync)
	); // (R19)

	assign req_low  = ~pins_sync[0];
	assign man_rst  = ~pins_sync[1];
	assign mode_ext = pins_sync[2];

	// release function halted in sleep with an all-stop value
	assign stopped  = SLEEP & all_stop(mstp_q); // (R8)
	assign rls_ok   = mode_ext & ctrl_q[`BRA_CTRL_RLS_EN] & ~stopped; // (R1)
	assign rls_want = req_low & rls_ok;

	// external access wanted by whichever master holds the internal bus
	assign int_ext_req = (hd_q[1] & CPU_EXT_REQ) | (hd_q[2] & TC_EXT_REQ);

	// ---------------------------------------------------------------
	// wishbone slave: one wait state, ack drops the cycle after it rose
	// ---------------------------------------------------------------
	assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;

	assign stat_word = {24'h000000,
		man_rst, ~drop_n_q, req_low, stopped,
		hd_q[2], hd_q[1], rs_q[1], rs_q[2]};

	// registers keep their contents through a manual reset
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			ctrl_q <= `BRA_CTRL_RST;
			mstp_q <= `BRA_MSTP_RST;
			ack_q  <= 1'b0;
			rdat_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= wb_req;
			// a write lands at the edge where the master samples ack high
			if (WB_CYC_I && WB_STB_I && ack_q && WB_WE_I)
			begin
				if (WB_ADR_I == `BRA_OFS_CTRL && WB_SEL_I[0])
					ctrl_q <= WB_DAT_I[1:0];
				if (WB_ADR_I == `BRA_OFS_MSTP)
					mstp_q <= lane_merge(mstp_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
			end
			// unmapped reads return zero
			if (wb_req && !WB_WE_I)
			begin
				case (WB_ADR_I)
					`BRA_OFS_CTRL: rdat_q <= {30'h0, ctrl_q};
					`BRA_OFS_MSTP: rdat_q <= {16'h0000, mstp_q};
					`BRA_OFS_STAT: rdat_q <= stat_word;
					default:       rdat_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// ---------------------------------------------------------------
	// transfer controller request: set on activation, set beats clear
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
			tc_req_q <= 1'b0;
		else if (TC_ACTIVATE)
			tc_req_q <= 1'b1; // (R14)
		else if (TC_DONE)
			tc_req_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// internal bus arbiter
	// ---------------------------------------------------------------
	// the holder only changes at its own break points or while the cpu sleeps, so a master is
	// never cut off inside a longword or a descriptor access
	always @*
	begin
		hd_d = hd_q;
		case (hd_q)
			HD_NONE:
			begin
				if (tc_req_q)
					hd_d = HD_TC; // (R10)
				else if (CPU_REQ)
					hd_d = HD_CPU; // (R9)
			end
			HD_CPU:
			begin
				if (tc_req_q && (CPU_BREAK || SLEEP))
					hd_d = HD_TC; // (R12) (R13)
				else if (!CPU_REQ)
					hd_d = HD_NONE;
			end
			HD_TC:
			begin
				if (TC_BREAK && !tc_req_q)
					hd_d = CPU_REQ ? HD_CPU : HD_NONE; // (R15)
			end
			default: hd_d = HD_NONE;
		endcase
		// manual reset freezes the holder, state is kept
		if (man_rst)
			hd_d = hd_q; // (R18)
	end

	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
			hd_q <= HD_NONE; // (R17)
		else
			hd_q <= hd_d;
	end

	// acknowledge stays high for as long as the master holds the bus
	assign CPU_ACK = hd_q[1]; // (R9)
	assign TC_ACK  = hd_q[2];

	// ---------------------------------------------------------------
	// external release state machine
	// ---------------------------------------------------------------
	always @*
	begin
		rs_d = rs_q;
		case (rs_q)
			RS_OWN:
			begin
				if (rls_want)
					rs_d = RS_DRAIN; // (R2)
			end
			RS_DRAIN:
			begin
				// let the running external cycle end before floating
				if (!rls_want)
					rs_d = RS_OWN;
				else if (!EXT_BUSY)
					rs_d = RS_REL; // (R16)
			end
			RS_REL:
			begin
				if (!req_low)
					rs_d = RS_OWN; // (R5)
			end
			default: rs_d = RS_OWN;
		endcase
	end

	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			rs_q      <= RS_OWN;
			grant_n_q <= 1'b1;
			drop_n_q  <= 1'b1;
		end
		else
		begin
			rs_q      <= rs_d;
			grant_n_q <= ~rs_d[2]; // (R2) (R5)
			// ask the outside master to give the bus back
			drop_n_q  <= ~(rs_d[2] & ctrl_q[`BRA_CTRL_DROP_EN] & int_ext_req); // (R4)
		end
	end

	assign BUS_GRANT_N        = grant_n_q;
	assign DROP_REQUEST_OUT_N = drop_n_q;

	// a new external cycle needs the bus owned and no release pending;
	// internal-only cycles never look at this, so they run during release
	assign EXT_GO = int_ext_req & rs_q[0] & ~rls_want & ~man_rst; // (R3) (R6) (R11)

	// finishing cycle under manual reset ignores the wait input
	assign WAIT_IGNORE = man_rst; // (R18)

	// ---------------------------------------------------------------
	// bus pins: registered values, all floated while released
	// ---------------------------------------------------------------
	// the read strobe is not forced high first; it may go low to float
	always @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			addr_q      <= 24'h000000;
			data_q      <= 16'h0000;
			data_oe_n_q <= 1'b1;
			pins_oe_n_q <= 1'b0;
			cs_n_q      <= {AREAS{1'b1}};
			as_n_q      <= 1'b1;
			rd_n_q      <= 1'b1;
			hwr_n_q     <= 1'b1;
			lwr_n_q     <= 1'b1;
		end
		else
		begin
			addr_q      <= ADDR_I;
			data_q      <= DATA_I;
			data_oe_n_q <= ~(DATA_DRIVE & ~rs_d[2]); // (R7)
			pins_oe_n_q <= rs_d[2]; // (R7) (R16)
			cs_n_q      <= AREA_SELECT_N_I;
			as_n_q      <= ADDRESS_STROBE_N_I;
			rd_n_q      <= READ_STROBE_N_I;
			hwr_n_q     <= UPPER_WRITE_STROBE_N_I;
			lwr_n_q     <= LOWER_WRITE_STROBE_N_I;
		end
	end

	assign ADDR_O                 = addr_q;
	assign ADDR_OE_N              = pins_oe_n_q;
	assign DATA_O                 = data_q;
	assign DATA_OE_N              = data_oe_n_q;
	assign AREA_SELECT_N_O        = cs_n_q;
	assign AREA_SELECT_OE_N       = pins_oe_n_q;
	assign ADDRESS_STROBE_N_O     = as_n_q;
	assign READ_STROBE_N_O        = rd_n_q;
	assign UPPER_WRITE_STROBE_N_O = hwr_n_q;
	assign LOWER_WRITE_STROBE_N_O = lwr_n_q;
	assign STROBE_OE_N            = pins_oe_n_q;

endmodule

// ### testbench/bra_checker.sv
// port-level assertions for the bus release arbiter
module bra_checker (
	// clock and reset
	input logic CLK_SYS,
	input logic NRST,
	// inputs watched
	input logic EXT_BUS_REQUEST_N,
	input logic MAN_RST_N,
	input logic CPU_REQ,
	input logic CPU_BREAK,
	input logic SLEEP,
	// outputs watched
	input logic BUS_GRANT_N,
	input logic DROP_REQUEST_OUT_N,
	input logic ADDR_OE_N,
	input logic STROBE_OE_N,
	input logic DATA_OE_N,
	input logic AREA_SELECT_OE_N,
	input logic CPU_ACK,
	input logic TC_ACK,
	input logic EXT_GO,
	input logic WAIT_IGNORE,
	input logic WB_ACK_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	// request removed while the outside master still holds the pins
	sequence rls_end;
		$rose(EXT_BUS_REQUEST_N) ##0 !BUS_GRANT_N;
	endsequence
	// manual reset seen through the synchroniser
	sequence mr_held;
		!MAN_RST_N [*3];
	endsequence
	AST_FLOAT: assert property (!BUS_GRANT_N |-> ADDR_OE_N && STROBE_OE_N
		&& DATA_OE_N && AREA_SELECT_OE_N) else $error("pins driven while released");
	AST_SYNC: assert property ($fell(BUS_GRANT_N) |-> !$past(EXT_BUS_REQUEST_N, 3)
		&& !$past(EXT_BUS_REQUEST_N, 4)) else $error("grant without held request");
	AST_END: assert property (rls_end |-> ##[1:4] BUS_GRANT_N)
		else $error("grant kept after request removed");
	AST_MR: assert property (mr_held |-> WAIT_IGNORE && !EXT_GO)
		else $error("manual reset not honoured");
	AST_GO: assert property (!BUS_GRANT_N |-> !EXT_GO)
		else $error("external cycle during release");
	AST_ONE: assert property (!(CPU_ACK && TC_ACK))
		else $error("two masters acknowledged");
	AST_CPU: assert property ($fell(CPU_ACK) && $past(CPU_REQ)
		|-> $past(CPU_BREAK) || $past(SLEEP)) else $error("cpu preempted mid cycle");
	AST_DROP: assert property ($fell(DROP_REQUEST_OUT_N) |-> !BUS_GRANT_N)
		else $error("drop request outside release");
	AST_ACK: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
endmodule

// ### testbench/bra_ext_master.sv
// outside bus master model that asks for and hands back the external bus
module bra_ext_master (
	// clock and reset
	input  logic clk,
	input  logic rst_n,
	// bench wish and device pin
	input  logic want,
	input  logic drop_n,
	output logic req_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic gave_up_q;
	// once asked to let go, stay off until the bench withdraws, so no quick re-request
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			gave_up_q <= 1'b0;
			req_n     <= 1'b1;
		end
		else
		begin
			gave_up_q <= want && (gave_up_q || !drop_n);
			req_n     <= !(want && !gave_up_q && drop_n);
		end
endmodule

// ### testbench/bra_bus_release_arbiter_tb_top.sv
// self-checking testbench for the bus release arbiter
module bra_bus_release_arbiter_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK_SYS = 1'b0, NRST = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
	logic        EXT_MODE = 1'b0, MAN_RST_N = 1'b1, SLEEP = 1'b0, want = 1'b0, EXT_BUSY = 1'b0;
	logic        CPU_REQ = 1'b0, CPU_BREAK = 1'b0, CPU_EXT_REQ = 1'b0;
	logic        TC_ACTIVATE = 1'b0, TC_DONE = 1'b0, TC_BREAK = 1'b1, TC_EXT_REQ = 1'b0;
	logic [52:0] pins_q = 53'h0;
	logic        nrst_q = 1'b0;
	logic [3:0]  WB_ADR_I = 4'h0, WB_SEL_I = 4'h0;
	logic [31:0] WB_DAT_I = 32'h0, seed = 32'hcbc2, d;
	logic [52:0] pins = 53'h0;
	logic [31:0] exp_q[$];
	wire  [31:0] WB_DAT_O;
	wire         WB_ACK_O, BUS_GRANT_N, DROP_REQUEST_OUT_N, CPU_ACK, TC_ACK, EXT_GO, WAIT_IGNORE;
	wire         EXT_BUS_REQUEST_N, ADDR_OE_N, DATA_OE_N, AREA_SELECT_OE_N, STROBE_OE_N;
	wire  [23:0] ADDR_O;
	wire  [15:0] DATA_O;
	wire  [7:0]  AREA_SELECT_N_O;
	wire         ADDRESS_STROBE_N_O, READ_STROBE_N_O;
	wire         UPPER_WRITE_STROBE_N_O, LOWER_WRITE_STROBE_N_O;
	wire  [27:0] pin_out = {LOWER_WRITE_STROBE_N_O, UPPER_WRITE_STROBE_N_O, READ_STROBE_N_O,
		ADDRESS_STROBE_N_O, AREA_SELECT_N_O, DATA_O};
	int          miscompares = 0, compares = 0;
	bra_bus_release_arbiter bra_bus_release_arbiter_inst (.CLK_SYS, .NRST, .WB_CYC_I,
		.WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .EXT_MODE,
		.MAN_RST_N, .SLEEP, .EXT_BUS_REQUEST_N, .BUS_GRANT_N, .DROP_REQUEST_OUT_N, .CPU_REQ,
		.CPU_BREAK, .CPU_EXT_REQ, .CPU_ACK, .TC_ACTIVATE, .TC_DONE, .TC_BREAK,
		.TC_EXT_REQ, .TC_ACK, .EXT_BUSY, .EXT_GO, .WAIT_IGNORE, .ADDR_I(pins[23:0]),
		.DATA_I(pins[39:24]), .DATA_DRIVE(pins[40]), .AREA_SELECT_N_I(pins[48:41]),
		.ADDRESS_STROBE_N_I(pins[49]), .READ_STROBE_N_I(pins[50]),
		.UPPER_WRITE_STROBE_N_I(pins[51]), .LOWER_WRITE_STROBE_N_I(pins[52]), .ADDR_O,
		.ADDR_OE_N, .DATA_O, .DATA_OE_N, .AREA_SELECT_N_O, .AREA_SELECT_OE_N,
		.ADDRESS_STROBE_N_O, .READ_STROBE_N_O, .UPPER_WRITE_STROBE_N_O,
		.LOWER_WRITE_STROBE_N_O, .STROBE_OE_N);
	bra_ext_master bra_ext_master_inst (.clk(CLK_SYS), .rst_n(NRST), .want(want),
		.drop_n(DROP_REQUEST_OUT_N), .req_n(EXT_BUS_REQUEST_N));
	// clock
	always #20 CLK_SYS = ~CLK_SYS;
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// engine pin values keep changing so the output copies are exercised
	always @(posedge CLK_SYS) pins <= 53'({xs(), xs()});
	task summarize();
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task bail();
		miscompares++;
		summarize();
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// scoreboard: each read answer is matched against the oldest note
	always @(posedge CLK_SYS)
		if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && exp_q.size() > 0)
			chk(WB_DAT_O, exp_q.pop_front());
	// pin copies trail the engine's values by one cycle; skip edges touched by reset
	always @(posedge CLK_SYS)
	begin
		if (NRST === 1'b1 && nrst_q === 1'b1)
		begin
			chk(32'(ADDR_O), 32'(pins_q[23:0]));
			chk(32'(pin_out), 32'({pins_q[52:41], pins_q[39:24]}));
		end
		pins_q <= pins;
		nrst_q <= NRST;
	end
	// one classic cycle; on a read v is the expected data
	task wb(input logic we, input logic [3:0] a, input logic [31:0] v);
		int n;
		@(posedge CLK_SYS);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I  <= we;
		WB_ADR_I <= a;
		WB_SEL_I <= 4'hf;
		WB_DAT_I <= v;
		if (!we)
			exp_q.push_back(v);
		n = 0;
		do
		begin
			@(posedge CLK_SYS);
			n++;
		end
		while (WB_ACK_O !== 1'b1 && n < 60);
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		if (n == 60)
			bail();
	endtask
	task tk(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	function logic cur(input int k);
		case (k)
			0: return BUS_GRANT_N;
			1: return DROP_REQUEST_OUT_N;
			2: return TC_ACK;
			default: return CPU_ACK;
		endcase
	endfunction
	// bounded wait for an output level, then compare it
	task wfor(input int k, input logic v);
		int n;
		n = 0;
		while (cur(k) !== v && n < 60)
		begin
			tk(1);
			n++;
		end
		if (n == 60)
			bail();
		chk(cur(k), v);
	endtask
	task pulse(input logic act);
		@(posedge CLK_SYS);
		TC_ACTIVATE <= act;
		TC_DONE     <= !act;
		@(posedge CLK_SYS);
		TC_ACTIVATE <= 1'b0;
		TC_DONE     <= 1'b0;
	endtask
	initial
	begin
		tk(10);
		NRST <= 1'b1;
		tk(3);
		wb(0, 4'h0, 32'h0);
		wb(0, 4'h4, 32'h3fff);
		wb(0, 4'hc, 32'h0);
		d = xs();
		wb(1, 4'h4, d);
		wb(0, 4'h4, {16'h0, d[15:0]});
		// release enabled but not in expansion mode, then a running external cycle
		wb(1, 4'h0, 32'h1);
		want <= 1'b1;
		tk(12);
		chk(BUS_GRANT_N, 1'b1);
		EXT_MODE <= 1'b1;
		EXT_BUSY <= 1'b1;
		tk(12);
		chk(BUS_GRANT_N, 1'b1);
		EXT_BUSY <= 1'b0;
		wfor(0, 1'b0);
		chk(ADDR_OE_N & DATA_OE_N & STROBE_OE_N & AREA_SELECT_OE_N, 1'b1);
		// cpu keeps the internal bus while its external cycle is held back
		CPU_REQ     <= 1'b1;
		CPU_EXT_REQ <= 1'b1;
		wfor(3, 1'b1);
		tk(4);
		chk({EXT_GO, DROP_REQUEST_OUT_N}, 2'b01);
		wb(0, 4'h8, 32'h25);
		wb(1, 4'h0, 32'h3);
		wfor(1, 1'b0);
		wfor(0, 1'b1);
		tk(2);
		chk(EXT_GO, 1'b1);
		want <= 1'b0;
		// transfer controller waits for a cpu cycle break
		pulse(1'b1);
		tk(4);
		chk({CPU_ACK, TC_ACK}, 2'b10);
		CPU_BREAK <= 1'b1;
		wfor(2, 1'b1);
		chk(EXT_GO, 1'b0);
		TC_EXT_REQ <= 1'b1;
		TC_BREAK   <= 1'b0;
		tk(2);
		chk(EXT_GO, 1'b1);
		TC_EXT_REQ <= 1'b0;
		pulse(1'b0);
		tk(4);
		chk(TC_ACK, 1'b1);
		TC_BREAK <= 1'b1;
		wfor(3, 1'b1);
		// a sleeping cpu hands over at once
		CPU_BREAK <= 1'b0;
		SLEEP     <= 1'b1;
		pulse(1'b1);
		wfor(2, 1'b1);
		pulse(1'b0);
		wfor(3, 1'b1);
		// manual reset keeps settings and blocks external cycles
		MAN_RST_N <= 1'b0;
		tk(4);
		chk({WAIT_IGNORE, EXT_GO}, 2'b10);
		MAN_RST_N <= 1'b1;
		wb(0, 4'h0, 32'h3);
		CPU_EXT_REQ <= 1'b0;
		// both all-stop values halt the release function in sleep
		for (int i = 0; i < 2; i++)
		begin
			wb(1, 4'h4, i ? 32'hefff : 32'hffff);
			want <= 1'b1;
			tk(12);
			chk(BUS_GRANT_N, 1'b1);
			want <= 1'b0;
			tk(4);
		end
		SLEEP <= 1'b0;
		want  <= 1'b1;
		wfor(0, 1'b0);
		// power-on reset in mid release drops everything at once
		NRST <= 1'b0;
		want <= 1'b0;
		#2;
		chk({BUS_GRANT_N, CPU_ACK}, 2'b10);
		tk(3);
		NRST <= 1'b1;
		tk(3);
		wb(0, 4'h0, 32'h0);
		summarize();
	end
endmodule
bind bra_bus_release_arbiter bra_checker bra_checker_inst (.CLK_SYS, .NRST, .EXT_BUS_REQUEST_N,
	.MAN_RST_N, .CPU_REQ, .CPU_BREAK, .SLEEP, .BUS_GRANT_N, .DROP_REQUEST_OUT_N, .ADDR_OE_N,
	.STROBE_OE_N, .DATA_OE_N, .AREA_SELECT_OE_N, .CPU_ACK, .TC_ACK, .EXT_GO, .WAIT_IGNORE,
	.WB_ACK_O);
